// >>> pkg/ipr_cfg.svh
// Offsets, field positions, reset values and widths for the interrupt priority register bank.
`ifndef IPR_CFG_SVH
`define IPR_CFG_SVH
`define IPR_OFF_DMA1_ADC_UART1TX   12'h000
`define IPR_OFF_CN_CMP_I2C1        12'h004
`define IPR_OFF_CAPTURE_EXT1       12'h008
`define IPR_OFF_TIMER4_COMPARE_DMA2 12'h00c
`define IPR_OFF_UART2_EXT2_TIMER5  12'h010
`define IPR_OFF_CAN_SPI2           12'h014
`define IPR_NUM_REGS               6
`define IPR_FIELDS_PER_REG         4
`define IPR_FIELD_W                3
`define IPR_FIELD_STRIDE           4
`define IPR_FIELD_RESET            3'h4
`define IPR_PRIO_OFF               3'h0
`define IPR_MASK_DMA1_ADC_UART1TX  16'h0777
`define IPR_MASK_CN_CMP_I2C1       16'h7777
`define IPR_MASK_CAPTURE_EXT1      16'h7707
`define IPR_MASK_TIMER4_COMPARE_DMA2 16'h7777
`define IPR_MASK_UART2_EXT2_TIMER5 16'h7777
`define IPR_MASK_CAN_SPI2          16'h7777
`define IPR_CAN_MASK               16'h7700
`define IPR_CAN_REG                5
`define IPR_NUM_SRC                24
`endif

// >>> pkg/ipr_pkg.sv
// Types shared by the interrupt priority register bank.
package ipr_pkg;
   typedef logic [2:0] ipr_level_type;
   typedef struct packed
   {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } ipr_apb_req_type;
   typedef struct packed
   {
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
   } ipr_apb_rsp_type;
endpackage : ipr_pkg

// >>> core/ipr_regs.sv
// Interrupt priority register bank with APB slave and per-source priority outputs.
//
// Local design decisions: the APB register port and the register addresses.
`timescale 1ns/1ps
`include "ipr_cfg.svh"

module ipr_regs
   import ipr_pkg::*;
#(
   parameter int NUM_REGS = `IPR_NUM_REGS
)
(
   input  wire logic                      clk_sys,
   input  wire logic                      srst,
   input  wire ipr_apb_req_type           apb_req,
   output      ipr_apb_rsp_type           apb_rsp,
   input  wire logic                      can_present,
   input  wire logic [`IPR_NUM_SRC-1:0]   src_pending,
   output      logic [`IPR_NUM_SRC*3-1:0] src_level,
   output      logic [`IPR_NUM_SRC-1:0]   src_request
);

   localparam logic [15:0] IMPL_MASK [0:`IPR_NUM_REGS-1] = '{
      `IPR_MASK_DMA1_ADC_UART1TX, `IPR_MASK_CN_CMP_I2C1, `IPR_MASK_CAPTURE_EXT1,
      `IPR_MASK_TIMER4_COMPARE_DMA2, `IPR_MASK_UART2_EXT2_TIMER5, `IPR_MASK_CAN_SPI2};
   localparam logic [15:0] CAN_MASK = `IPR_CAN_MASK;
   localparam logic [11:0] REG_OFF [0:`IPR_NUM_REGS-1] = '{
      `IPR_OFF_DMA1_ADC_UART1TX, `IPR_OFF_CN_CMP_I2C1, `IPR_OFF_CAPTURE_EXT1,
      `IPR_OFF_TIMER4_COMPARE_DMA2, `IPR_OFF_UART2_EXT2_TIMER5, `IPR_OFF_CAN_SPI2};

   logic [15:0]               prio_reg [0:`IPR_NUM_REGS-1];
   logic [15:0]               next_prio [0:`IPR_NUM_REGS-1];
   logic [`IPR_NUM_REGS-1:0]  hit;
   logic                      wr_access;
   logic                      can_present_meta;
   logic                      can_present_sync;

   // The variant strap comes from outside, so it is synchronised before use.
   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         can_present_meta <= 1'b0;
         can_present_sync <= 1'b0;
      end
      else
      begin
         can_present_meta <= can_present;
         can_present_sync <= can_present_meta;
      end
   end

   assign wr_access = apb_req.psel && apb_req.penable && apb_req.pwrite;

   genvar gr;
   genvar gf;
   generate
      for (gr = 0; gr < `IPR_NUM_REGS; gr++)
      begin : g_reg
         assign hit[gr] = (apb_req.paddr == REG_OFF[gr]);

         // Unimplemented bits are masked off on write, so they always read back zero.
         always_comb
         begin
            next_prio[gr] = prio_reg[gr];
            if (wr_access && hit[gr])
            begin
               next_prio[gr] = apb_req.pwdata[15:0] & IMPL_MASK[gr];
            end
         end

         always_ff @(posedge clk_sys)
         begin
            if (srst)
            begin
               prio_reg[gr] <= {4{1'b0, `IPR_FIELD_RESET}} & IMPL_MASK[gr];
            end
            else
            begin
               prio_reg[gr] <= next_prio[gr];
            end
         end

         for (gf = 0; gf < `IPR_FIELDS_PER_REG; gf++)
         begin : g_field
            localparam int SRC = gr * `IPR_FIELDS_PER_REG + gf;
            localparam bit IS_CAN = (gr == `IPR_CAN_REG) && CAN_MASK[gf*4];
            ipr_level_type lvl;
            // The field is forwarded from the write data, so a write is seen without delay.
            assign lvl = next_prio[gr][gf*`IPR_FIELD_STRIDE +: `IPR_FIELD_W];

            always_ff @(posedge clk_sys)
            begin
               if (srst)
               begin
                  src_level[SRC*3 +: 3] <= 3'h0;
                  src_request[SRC]      <= 1'b0;
               end
               else
               begin
                  src_level[SRC*3 +: 3] <= lvl;
                  src_request[SRC] <= src_pending[SRC] && (lvl != `IPR_PRIO_OFF)
                                      && (!IS_CAN || can_present_sync);
               end
            end
         end
      end
   endgenerate

   // Reads are answered with zero wait states; an unmapped address reads zero with an error.
   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         apb_rsp <= '0;
      end
      else
      begin
         apb_rsp.pready  <= apb_req.psel && !apb_req.penable;
         apb_rsp.pslverr <= apb_req.psel && !apb_req.penable && (hit == '0);
         apb_rsp.prdata  <= 32'h0;
         for (int i = 0; i < `IPR_NUM_REGS; i++)
         begin
            if (hit[i] && apb_req.psel && !apb_req.penable)
            begin
               apb_rsp.prdata <= {16'h0, prio_reg[i]};
            end
         end
      end
   end

endmodule : ipr_regs

// >>> test/ipr_regs_monitor.sv
// Port checker for the priority bank.
`timescale 1ns/1ps
module ipr_regs_monitor import ipr_pkg::*; (
   input wire logic clk_sys, srst,
   input wire ipr_apb_req_type apb_req,
   input wire ipr_apb_rsp_type apb_rsp,
   input wire logic can_present,
   input wire logic [23:0] src_pending, src_request,
   input wire logic [71:0] src_level);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (srst);
   sequence su_s; apb_req.psel && !apb_req.penable; endsequence
   rdy_next_a: assert property (su_s |=> apb_rsp.pready) else $error("ready");
   rdy_pulse_a: assert property (apb_rsp.pready |=> !apb_rsp.pready) else $error("pulse");
   bad_addr_a: assert property (su_s ##0 apb_req.paddr > 12'h014 |=> apb_rsp.pslverr) else $error("slverr");
   pad_zero_a: assert property (apb_rsp.pready |-> !(apb_rsp.prdata & 32'hffff_8888)) else $error("pad");
   off_quiet_a: assert property (src_level[62:60] == 3'h0 |-> !src_request[20]) else $error("off");
   need_pend_a: assert property (!(src_request & ~$past(src_pending))) else $error("pend");
   can_off_a: assert property (!can_present [*5] |-> !src_request[23:22]) else $error("can");
   wr_link_a: assert property (su_s ##1 apb_req.pwrite && apb_req.paddr == 12'h004 |=>
      src_level[14:12] == $past(apb_req.pwdata[2:0])) else $error("link");
endmodule : ipr_regs_monitor

// >>> test/test_interrupt_priority_regs.sv
// Bench for the priority bank.
`timescale 1ns/1ps
module test_interrupt_priority_regs import ipr_pkg::*;;
   logic clk_sys = 1'b0, srst = 1'b1, can_present = 1'b1;
   logic [23:0] src_pending = 24'h0, src_request;
   logic [71:0] src_level;
   ipr_apb_req_type apb_req = '0;
   ipr_apb_rsp_type apb_rsp;
   int error_cnt = 0, n_checks = 0;
   logic [31:0] rd = 32'h0;
   logic err = 1'b0;
   logic [95:0] msk = 96'h7777_7777_7777_7707_7777_0777;
   always #25 clk_sys = ~clk_sys;
   ipr_regs dut (.*);
   task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
      @(posedge clk_sys);
      apb_req <= '{1'b1, 1'b0, w, a, d};
      @(posedge clk_sys);
      apb_req.penable <= 1'b1;
      do @(posedge clk_sys); while (apb_rsp.pready !== 1'b1);
      rd = apb_rsp.prdata;
      err = apb_rsp.pslverr;
      apb_req <= '0;
   endtask : apb
   task automatic chk(string n, logic [31:0] s, x);
      n_checks++;
      error_cnt += int'(s !== x);
      if (s !== x) $display("CHECK FAILED %s exp %h seen %h", n, x, s);
   endtask : chk
   task automatic finish_test(int t);
      error_cnt += t;
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : finish_test
   task automatic t_regs;
      for (int i = 0; i < 6; i++)
      begin
         apb(1'b0, 12'(4*i), 32'h0);
         chk("reset", rd, msk[16*i+:16] & 16'h4444);
         apb(1'b1, 12'(4*i), '1);
         apb(1'b0, 12'(4*i), 32'h0);
         chk("ones", rd, msk[16*i+:16]);
      end
      apb(1'b0, 12'h018, 32'h0);
      chk("unmapped", err, 32'h1);
      $display("regs done");
   endtask : t_regs
   task automatic t_req;
      src_pending <= '1;
      apb(1'b1, 12'h000, 32'h0321);
      apb(1'b1, 12'h014, 32'h7700);
      @(posedge clk_sys);
      chk("request", src_request, 24'hcffdf7);
      can_present <= 1'b0;
      repeat (6) @(posedge clk_sys);
      chk("no can", src_request, 24'h0ffdf7);
      $display("req done");
   endtask : t_req
   initial
   begin
      repeat (3) @(posedge clk_sys);
      srst <= 1'b0;
      t_regs;
      t_req;
      finish_test(0);
   end
   initial #60000 finish_test(1);
endmodule : test_interrupt_priority_regs
bind ipr_regs ipr_regs_monitor mon (.*);
